// ---- include/pkh_regs.vh ----
// register map, field positions, reset values and timing counts of the keystroke port
`ifndef PKH_REGS_VH
`define PKH_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PKH_OFS_CTRL 8'h00
`define PKH_OFS_STATUS 8'h04
`define PKH_OFS_LAST 8'h08
`define PKH_OFS_COUNT 8'h0c
`define PKH_OFS_ID 8'h10

// ---------------------------------------------------------------
// control fields and reset values
// ---------------------------------------------------------------
`define PKH_CTRL_ENABLE_BIT 0
`define PKH_CTRL_CLR_HELD_BIT 1
`define PKH_CTRL_ENABLE_RST 1'b1

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define PKH_ST_ACK_BIT 0
`define PKH_ST_BUSY_BIT 1
`define PKH_ST_PULLUP_BIT 2
`define PKH_ST_HELD_BIT 3
`define PKH_ST_STROBE_BIT 4
`define PKH_ST_HOLD_BIT 5
`define PKH_ST_ACKPIN_BIT 6

// ---------------------------------------------------------------
// hid report layout and descriptor constants
// ---------------------------------------------------------------
`define PKH_RPT_MOD_LSB 0
`define PKH_RPT_KEY_LSB 16
`define PKH_COUNTRY_CODE 8'h00
`define PKH_IDLE_KEY 8'h00
`define PKH_MOD_LCTRL 0
`define PKH_MOD_LSHIFT 1
`define PKH_MOD_LALT 2
`define PKH_MOD_LGUI 3
`define PKH_MOD_RCTRL 4
`define PKH_MOD_RSHIFT 5
`define PKH_MOD_RALT 6
`define PKH_MOD_RGUI 7

// ---------------------------------------------------------------
// axi responses
// ---------------------------------------------------------------
`define PKH_RESP_OKAY 2'b00
`define PKH_RESP_SLVERR 2'b10

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PKH_CLK_PERIOD_NS 10
`define PKH_POR_TIME_NS 10000
`define PKH_POR_CYCLES ((`PKH_POR_TIME_NS + `PKH_CLK_PERIOD_NS - 1) / `PKH_CLK_PERIOD_NS)

`endif

// ---- src/pkh_sync.v ----
// three-stage input synchroniser whose output follows once stages two and three agree
`timescale 1ns/100ps
module pkh_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  // ---------------------------------------------------------------
  // per-bit chain
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg s1_r; // first stage, read only by the second
      reg s2_r;
      reg s3_r;
      reg out_r; // filtered level
      // the output moves only when two settled stages agree, so a glitch is dropped
      always @(posedge clk) begin
        if (sys_rst) begin
          s1_r <= INIT[gi];
          s2_r <= INIT[gi];
          s3_r <= INIT[gi];
          out_r <= INIT[gi];
        end else begin
          s1_r <= din[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            out_r <= s3_r;
          end
        end
      end
      assign dout[gi] = out_r;
    end
  endgenerate

endmodule // pkh_sync

// ---- src/pkh_por.v ----
// power-up sequencer: enables input pull-ups, then declares the port ready
`timescale 1ns/100ps
`include "pkh_regs.vh"
module pkh_por #(
  parameter POR_CYC = `PKH_POR_CYCLES
) (
  input wire clk,
  input wire sys_rst,
  output wire pullup_en,
  output wire por_done
);

  // ---------------------------------------------------------------
  // sequence counter
  // ---------------------------------------------------------------
  reg [15:0] cnt_r; // cycles since reset release
  reg pullup_r; // pull-ups start off and come on during the sequence
  reg done_r; // inputs have settled with pull-ups on

  // pull-ups come on at the first edge; inputs are trusted only after the wait
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      pullup_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      pullup_r <= 1'b1;
      if (!done_r) begin
        if (cnt_r == POR_CYC[15:0] - 16'h0001) begin
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

  assign pullup_en = pullup_r;
  assign por_done = done_r;

endmodule // pkh_por

// ---- src/pkh_top.v ----
// parallel keystroke port that turns strobed codes into hid boot keyboard reports
`timescale 1ns/100ps
`include "pkh_regs.vh"

// Notes on behaviour
// - key code plus six modifiers form one report
// - modifier inputs are active low
// - alt and gui both sides, ctrl/shift right only
// - strobe low captures and sends one keystroke
// - acknowledge pulled low once inputs are taken
// - each key sent as press then release
// - hold high keeps modifiers until next strobe
// - hold low clears modifiers after each keystroke
// - enumerates as boot protocol hid keyboard
// - country code is zero, not localized
// - every usage code forwarded unchanged
// - power-up sequence enables input pull-ups
module pkh_top #(
  parameter ADDR_W = 8,
  parameter POR_CYC = `PKH_POR_CYCLES,
  parameter [31:0] ID_VALUE = 32'h00c0ffee // arbitrary value
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] key_code_in,
  input wire left_alt_mod_n,
  input wire left_gui_mod_n,
  input wire right_ctrl_mod_n,
  input wire right_shift_mod_n,
  input wire right_alt_mod_n,
  input wire right_gui_mod_n,
  input wire keystroke_strobe_n,
  input wire hold_in,
  input wire ack_n_in,
  output reg ack_n_out,
  output reg ack_n_oe,
  output wire pullup_en,
  output reg rpt_valid,
  output reg [63:0] rpt_data,
  input wire rpt_ready,
  output reg [7:0] hid_country_code,
  output reg hid_boot_subclass,
  output reg hid_kbd_protocol,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ---------------------------------------------------------------
  // state encoding
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00; // waiting for a strobe edge
  localparam [1:0] ST_DOWN = 2'b01; // press report offered
  localparam [1:0] ST_UP = 2'b10; // release report offered
  localparam [1:0] ST_WAIT = 2'b11; // waiting for strobe to go high

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  wire [16:0] pin_raw; // every asynchronous pin in one bundle
  wire [16:0] pin_sync; // filtered levels
  wire por_done; // inputs settled after power-up
  wire [7:0] key_s; // synchronised key code
  wire [5:0] mod_n_s; // synchronised modifiers, active low
  wire strobe_n_s; // synchronised strobe
  wire hold_s; // synchronised hold level
  wire ack_pin_s; // level seen on the acknowledge wire

  assign pin_raw = {ack_n_in, hold_in, keystroke_strobe_n, right_gui_mod_n, right_alt_mod_n,
                    right_shift_mod_n, right_ctrl_mod_n, left_gui_mod_n, left_alt_mod_n,
                    key_code_in};

  // strobe, code and modifiers share one path so their lag is equal
  pkh_sync #(
    .WIDTH(17),
    .INIT(17'h17fff)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(pin_raw),
    .dout(pin_sync)
  );

  pkh_por #(
    .POR_CYC(POR_CYC)
  ) u_por (
    .clk(clk),
    .sys_rst(sys_rst),
    .pullup_en(pullup_en),
    .por_done(por_done)
  );

  assign key_s = pin_sync[7:0];
  assign mod_n_s = pin_sync[13:8];
  assign strobe_n_s = pin_sync[14];
  assign hold_s = pin_sync[15];
  assign ack_pin_s = pin_sync[16];

  // ---------------------------------------------------------------
  // modifier mapping into the hid modifier byte
  // ---------------------------------------------------------------
  reg [7:0] mod_byte; // active-high modifier byte from the pins

  // left ctrl and left shift have no pin and always read released
  always @* begin
    mod_byte = 8'h00;
    mod_byte[`PKH_MOD_LALT] = ~mod_n_s[0];
    mod_byte[`PKH_MOD_LGUI] = ~mod_n_s[1];
    mod_byte[`PKH_MOD_RCTRL] = ~mod_n_s[2];
    mod_byte[`PKH_MOD_RSHIFT] = ~mod_n_s[3];
    mod_byte[`PKH_MOD_RALT] = ~mod_n_s[4];
    mod_byte[`PKH_MOD_RGUI] = ~mod_n_s[5];
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  reg enable_r; // accepts strobes only while set
  reg clr_held_r; // one-cycle pulse that drops held modifiers if idle
  reg [1:0] state_r; // handshake state
  reg [1:0] state_nxt;
  reg strobe_prev_r; // previous filtered strobe level
  reg [7:0] key_r; // captured usage code
  reg [7:0] mod_r; // captured modifier byte
  reg [7:0] held_r; // modifiers reported while idle
  reg [15:0] count_r; // accepted keystrokes
  wire strobe_fall; // one-cycle falling edge of the strobe
  wire take; // a keystroke is captured this cycle

  assign strobe_fall = strobe_prev_r & ~strobe_n_s;
  // edges outside idle are ignored: a source that strobes early breaks its own side
  assign take = (state_r == ST_IDLE) & strobe_fall & enable_r & por_done;

  // ---------------------------------------------------------------
  // handshake state machine
  // ---------------------------------------------------------------
  // next-state logic: press, release, then wait for the strobe to return high
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (rpt_ready) begin
          state_nxt = ST_UP;
        end
      end
      ST_UP: begin
        if (rpt_ready) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (strobe_n_s) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state, capture and report registers
  always @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      strobe_prev_r <= 1'b1;
      key_r <= 8'h00;
      mod_r <= 8'h00;
      held_r <= 8'h00;
      count_r <= 16'h0000;
      rpt_valid <= 1'b0;
      rpt_data <= 64'h0000000000000000;
      ack_n_out <= 1'b0;
      ack_n_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      strobe_prev_r <= strobe_n_s;
      ack_n_out <= 1'b0; // open drain: only ever pulls low
      // capture outranks a software clear of the held byte in the same cycle
      if (take) begin
        key_r <= key_s;
        mod_r <= mod_byte;
        count_r <= count_r + 16'h0001;
        ack_n_oe <= 1'b1;
        rpt_valid <= 1'b1;
        rpt_data <= 64'h0000000000000000;
        rpt_data[`PKH_RPT_MOD_LSB +: 8] <= mod_byte;
        rpt_data[`PKH_RPT_KEY_LSB +: 8] <= key_s;
      end else if (state_r == ST_DOWN && rpt_ready) begin
        // press taken: the release keeps modifiers only under hold
        rpt_data <= 64'h0000000000000000;
        rpt_data[`PKH_RPT_KEY_LSB +: 8] <= `PKH_IDLE_KEY;
        if (hold_s) begin
          rpt_data[`PKH_RPT_MOD_LSB +: 8] <= mod_r;
          held_r <= mod_r;
        end else begin
          held_r <= 8'h00;
        end
      end else if (state_r == ST_UP && rpt_ready) begin
        rpt_valid <= 1'b0; // both reports queued
      end else if (state_r == ST_WAIT && strobe_n_s) begin
        ack_n_oe <= 1'b0;
      end else if (clr_held_r && state_r == ST_IDLE) begin
        held_r <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // descriptor facts seen by the usb stack
  // ---------------------------------------------------------------
  // held in flops; country code is steady from reset on, subclass and protocol read zero in reset and one after it
  always @(posedge clk) begin
    if (sys_rst) begin
      hid_country_code <= `PKH_COUNTRY_CODE;
      hid_boot_subclass <= 1'b0;
      hid_kbd_protocol <= 1'b0;
    end else begin
      hid_country_code <= `PKH_COUNTRY_CODE;
      hid_boot_subclass <= 1'b1;
      hid_kbd_protocol <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  reg aw_got_r; // address accepted, waiting for data
  reg w_got_r; // data accepted, waiting for address
  reg [ADDR_W-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire aw_fire;
  wire w_fire;
  wire wr_go; // both halves present, perform the write

  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;

  // address and data may arrive in either order; one write at a time
  always @(posedge clk) begin
    if (sys_rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PKH_RESP_OKAY;
      enable_r <= `PKH_CTRL_ENABLE_RST;
      clr_held_r <= 1'b0;
    end else begin
      clr_held_r <= 1'b0;
      s_axi_awready <= ~aw_got_r & ~aw_fire & ~s_axi_bvalid;
      s_axi_wready <= ~w_got_r & ~w_fire & ~s_axi_bvalid;
      if (aw_fire) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PKH_RESP_OKAY;
        case (awaddr_r)
          `PKH_OFS_CTRL: begin
            if (wstrb_r[0]) begin
              enable_r <= wdata_r[`PKH_CTRL_ENABLE_BIT];
              clr_held_r <= wdata_r[`PKH_CTRL_CLR_HELD_BIT];
            end
          end
          `PKH_OFS_STATUS, `PKH_OFS_LAST, `PKH_OFS_COUNT, `PKH_OFS_ID: begin
            s_axi_bresp <= `PKH_RESP_OKAY; // read-only, write dropped
          end
          default: begin
            s_axi_bresp <= `PKH_RESP_SLVERR; // nothing mapped here
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  reg [31:0] rd_word; // decoded read value
  reg rd_err; // unmapped read address
  wire ar_fire;

  assign ar_fire = s_axi_arvalid & s_axi_arready;

  // read decode; reserved bits read as zero
  always @* begin
    rd_word = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `PKH_OFS_CTRL: begin
        rd_word[`PKH_CTRL_ENABLE_BIT] = enable_r;
      end
      `PKH_OFS_STATUS: begin
        rd_word[`PKH_ST_ACK_BIT] = ack_n_oe;
        rd_word[`PKH_ST_BUSY_BIT] = (state_r != ST_IDLE);
        rd_word[`PKH_ST_PULLUP_BIT] = pullup_en;
        rd_word[`PKH_ST_HELD_BIT] = |held_r;
        rd_word[`PKH_ST_STROBE_BIT] = strobe_n_s;
        rd_word[`PKH_ST_HOLD_BIT] = hold_s;
        rd_word[`PKH_ST_ACKPIN_BIT] = ack_pin_s;
      end
      `PKH_OFS_LAST: begin
        rd_word[15:0] = {mod_r, key_r};
      end
      `PKH_OFS_COUNT: begin
        rd_word[15:0] = count_r;
      end
      `PKH_OFS_ID: begin
        rd_word = ID_VALUE;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // address taken in one cycle, data answered on the next
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PKH_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_err ? `PKH_RESP_SLVERR : `PKH_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pkh_top

// ---- sim/pkh_top_assertions.sv ----
// concurrent checks on the keystroke port and report outputs
`timescale 1ns/100ps
module pkh_top_assertions (
  input wire clk,
  input wire sys_rst,
  input wire keystroke_strobe_n,
  input wire hold_in,
  input wire ack_n_out,
  input wire ack_n_oe,
  input wire pullup_en,
  input wire rpt_valid,
  input wire [63:0] rpt_data,
  input wire rpt_ready,
  input wire [7:0] hid_country_code,
  input wire hid_boot_subclass,
  input wire hid_kbd_protocol
);
  // -----------------------------------------
  // one clock domain, checks idle in reset
  // -----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_with_press: assert property (
    $rose(ack_n_oe) |-> $rose(rpt_valid)) else $error("ack without press report");
  a_strobe_synced: assert property (
    $rose(ack_n_oe) |-> !$past(keystroke_strobe_n, 3)) else $error("strobe taken too early");
  a_ack_drives_low: assert property (
    ack_n_oe |-> ack_n_out == 1'b0) else $error("ack driven high");
  a_ack_until_taken: assert property (
    ack_n_oe && rpt_valid |=> ack_n_oe) else $error("ack released with report pending");
  a_ack_release: assert property (
    $fell(ack_n_oe) |-> $past(keystroke_strobe_n, 2) && !rpt_valid)
    else $error("ack released while strobe low");
  a_press_release: assert property (
    rpt_valid && rpt_ready && rpt_data[23:16] != 8'h00 |=> rpt_valid && rpt_data[23:16] == 8'h00)
    else $error("press not followed by release");
  a_mods_cleared: assert property (
    rpt_valid && rpt_ready && rpt_data[23:16] != 8'h00 && !hold_in |=> rpt_data[7:0] == 8'h00)
    else $error("modifiers kept without hold");
  a_mods_held: assert property (
    rpt_valid && rpt_ready && rpt_data[23:16] != 8'h00 && hold_in
    |=> rpt_data[7:0] == $past(rpt_data[7:0])) else $error("modifiers lost under hold");
  a_report_stands: assert property (
    rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_data)) else $error("report changed");
  a_unused_bits: assert property (
    rpt_valid |-> rpt_data[1:0] == 2'b00 && rpt_data[15:8] == 8'h00 && rpt_data[63:24] == 40'h0)
    else $error("unused report bits set");
  a_country_zero: assert property (
    hid_country_code == 8'h00) else $error("country code not zero");
  a_boot_kbd: assert property (
    !$past(sys_rst) |-> hid_boot_subclass && hid_kbd_protocol) else $error("not boot keyboard");
  a_pullup_on: assert property (
    !$past(sys_rst) |-> pullup_en) else $error("pull-ups not enabled");
endmodule // pkh_top_assertions

bind pkh_top pkh_top_assertions chk_i (.clk, .sys_rst, .keystroke_strobe_n, .hold_in,
  .ack_n_out, .ack_n_oe, .pullup_en, .rpt_valid, .rpt_data, .rpt_ready, .hid_country_code,
  .hid_boot_subclass, .hid_kbd_protocol);

// ---- sim/pkh_src_model.sv ----
// keystroke source model that drives code, modifiers and strobe
`timescale 1ns/100ps
module pkh_src_model (
  input wire clk,
  input wire ack_n_in,
  output logic [7:0] key_code_in,
  output logic left_alt_mod_n,
  output logic left_gui_mod_n,
  output logic right_ctrl_mod_n,
  output logic right_shift_mod_n,
  output logic right_alt_mod_n,
  output logic right_gui_mod_n,
  output logic keystroke_strobe_n
);
  // released lines sit at their pull-up level
  initial begin
    key_code_in = 8'hff;
    {right_gui_mod_n, right_alt_mod_n, right_shift_mod_n} = 3'b111;
    {right_ctrl_mod_n, left_gui_mod_n, left_alt_mod_n} = 3'b111;
    keystroke_strobe_n = 1'b1;
  end
  // one handshake; m bit0 left alt .. bit5 right gui, ok low if never acknowledged
  task automatic stroke(input [7:0] c, input [5:0] m, output bit ok);
    int n;
    begin
      n = 0;
      while (!ack_n_in) @(posedge clk);
      key_code_in <= c;
      {right_gui_mod_n, right_alt_mod_n, right_shift_mod_n} <= ~m[5:3];
      {right_ctrl_mod_n, left_gui_mod_n, left_alt_mod_n} <= ~m[2:0];
      @(posedge clk);
      keystroke_strobe_n <= 1'b0;
      while (ack_n_in && n < 40) begin
        @(posedge clk);
        n++;
      end
      ok = !ack_n_in;
      keystroke_strobe_n <= 1'b1;
      key_code_in <= 8'hff;
      {right_gui_mod_n, right_alt_mod_n, right_shift_mod_n} <= 3'b111;
      {right_ctrl_mod_n, left_gui_mod_n, left_alt_mod_n} <= 3'b111;
      while (!ack_n_in) @(posedge clk);
    end
  endtask
endmodule // pkh_src_model

// ---- sim/tb_top.sv ----
// self-checking bench for the parallel keystroke port
`timescale 1ns/100ps
module tb_top;
  localparam [31:0] ID = 32'h5a5a0001; // arbitrary value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hold_in = 1'b0;
  logic rpt_ready = 1'b0;
  logic slow = 1'b0; // stalls the report taker
  logic [1:0] tick = 2'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire [7:0] key_code_in, hid_country_code;
  wire left_alt_mod_n, left_gui_mod_n, right_ctrl_mod_n, right_shift_mod_n;
  wire right_alt_mod_n, right_gui_mod_n, keystroke_strobe_n, ack_n_out, ack_n_oe, pullup_en;
  wire rpt_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire hid_boot_subclass, hid_kbd_protocol;
  wire [63:0] rpt_data;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire ack_n_in = ack_n_oe ? ack_n_out : 1'b1; // open drain with pull-up
  int miscompares = 0;
  int checks_done = 0;
  logic [63:0] q[$]; // reports taken by the usb side
  pkh_top #(.POR_CYC(4), .ID_VALUE(ID)) dut (.*);
  pkh_src_model src (.*);
  initial forever #5 clk = ~clk;
  // usb side taker, stalls three cycles of four when slow
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    rpt_ready <= !slow || (tick == 2'h3);
    if (rpt_valid && rpt_ready) q.push_back(rpt_data);
  end
  task automatic chk(input [63:0] got, input [63:0] exp);
    begin
      checks_done++;
      if (got !== exp) begin
        miscompares++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // axi write; both halves offered together, each dropped once taken
  task automatic axw(input [7:0] a, input [31:0] d, input [1:0] er);
    logic dn;
    begin
      dn = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!dn) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        dn = s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
      @(posedge clk);
    end
  endtask
  task automatic axr(input [7:0] a, input [31:0] ed, input [1:0] er);
    logic dn;
    begin
      dn = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!dn) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        dn = s_axi_rvalid;
      end
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      @(posedge clk);
    end
  endtask
  // one keystroke and its two reports; en says whether it should be accepted
  task automatic key_try(input [7:0] c, input [5:0] m, input h, input en);
    bit ok;
    logic [7:0] em;
    begin
      em = {m, 2'b00};
      hold_in <= h;
      q.delete();
      @(posedge clk);
      src.stroke(c, m, ok);
      repeat (3) @(posedge clk);
      chk(ok, en);
      chk(q.size(), en ? 2 : 0);
      if (en && q.size() == 2) begin
        chk(q[0], {40'h0, c, 8'h00, em});
        chk(q[1], {56'h0, h ? em : 8'h00});
      end
    end
  endtask
  task automatic wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end
  // -----------------------------------------
  // main sequence
  // -----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    axr(8'h00, 32'h1, 2'b00);
    axr(8'h04, 32'h54, 2'b00);
    axr(8'h10, ID, 2'b00);
    axw(8'h10, 32'h0, 2'b00);
    axr(8'h10, ID, 2'b00);
    axr(8'h40, 32'h0, 2'b10);
    axw(8'h40, 32'h0, 2'b10);
    key_try(8'h04, 6'h08, 1'b0, 1'b1);
    key_try(8'hdf, 6'h03, 1'b0, 1'b1);
    key_try(8'hff, 6'h24, 1'b0, 1'b1);
    slow <= 1'b1;
    key_try(8'h00, 6'h30, 1'b1, 1'b1);
    key_try(8'h2a, 6'h3f, 1'b1, 1'b1);
    axr(8'h04, 32'h7c, 2'b00);
    axw(8'h00, 32'h3, 2'b00);
    axr(8'h04, 32'h74, 2'b00);
    key_try(8'h1e, 6'h00, 1'b1, 1'b1);
    s_axi_wstrb <= 4'he;
    axw(8'h00, 32'h0, 2'b00);
    s_axi_wstrb <= 4'hf;
    axr(8'h00, 32'h1, 2'b00);
    axw(8'h00, 32'h0, 2'b00);
    key_try(8'h05, 6'h01, 1'b0, 1'b0);
    axw(8'h00, 32'h1, 2'b00);
    key_try(8'h06, 6'h10, 1'b0, 1'b1);
    axr(8'h0c, 32'h7, 2'b00);
    axr(8'h08, 32'h4006, 2'b00);
    wrap_up();
  end
endmodule // tb_top
